/* hw/orirt_axis.sv */
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module orirt_axis
   import orirt_pkg::*;
#(
   parameter int FEED_WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic startSelect,
   input wire logic originIn,
   input wire logic zphaseIn,
   input wire logic atLowSpeed,
   input wire logic decelerating,
   input wire logic errorStop,
   input wire logic shared_slowdown_line_in,
   output logic shared_slowdown_line_out,
   output logic shared_slowdown_line_oe,
   input wire logic shared_stop_line_in,
   output logic shared_stop_line_out,
   output logic shared_stop_line_oe,
   input wire logic pulseTick,
   output logic pulseOut,
   output logic direction,
   output logic running,
   output logic deviation_clear_out
);
   logic [7:0] axis_operation_mode;
   logic [15:0] env;
   logic [FEED_WIDTH-1:0] feed_amount;
   logic [FEED_WIDTH-1:0] interp_range;
   logic [FEED_WIDTH-1:0] interpAcc;
   logic [FEED_WIDTH-1:0] counterOne;
   logic [FEED_WIDTH-1:0] counterTwo;
   logic [FEED_WIDTH-1:0] feedAbs;
   logic [FEED_WIDTH:0] accSum;
   logic [3:0] zphase_down_counter;
   logic zcount_event_flag;
   logic [2:0] orgSync;
   logic [2:0] zSync;
   logic [2:0] sdSync;
   logic [2:0] stpSync;
   logic orgLevel;
   logic zLevel;
   logic orgRise;
   logic zEdge;
   logic sharedStop;
   logic sharedSlow;
   logic errHit;
   logic doneHit;
   logic isOrigin;
   logic isInterp;
   logic cmdWrite;
   logic startCmd;
   logic stopCmd;
   logic incrDone;
   logic [FEED_WIDTH-1:0] dummyCount;
   logic [$clog2(CLR_PULSE_CYCLES+1)-1:0] clrCount;
   orirt_state_type state;
   orirt_state_type next_state;

   // input pins: three stages, a change counts when stages two and three agree
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         orgSync <= 3'b000;
         zSync <= 3'b000;
         sdSync <= 3'b111;
         stpSync <= 3'b111;
      end else begin
         orgSync <= {orgSync[1:0], originIn};
         zSync <= {zSync[1:0], zphaseIn};
         sdSync <= {sdSync[1:0], shared_slowdown_line_in};
         stpSync <= {stpSync[1:0], shared_stop_line_in};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         orgLevel <= 1'b0;
         zLevel <= 1'b0;
         sharedStop <= 1'b0;
         sharedSlow <= 1'b0;
      end else begin
         if (orgSync[1] == orgSync[2]) begin
            orgLevel <= orgSync[2];
         end
         if (zSync[1] == zSync[2]) begin
            zLevel <= zSync[2];
         end
         if (stpSync[1] == stpSync[2]) begin
            sharedStop <= !stpSync[2];
         end
         if (sdSync[1] == sdSync[2]) begin
            sharedSlow <= !sdSync[2];
         end
      end
   end

   assign orgRise = (orgSync[1] == orgSync[2]) && orgSync[2] && !orgLevel;
   // edge polarity selected by software
   assign zEdge = (zSync[1] == zSync[2]) && (zSync[2] != zLevel) &&
                  (zSync[2] == env[ENV_ZEDGE]);

   assign isOrigin = (axis_operation_mode == MODE_ORIGIN_POS) || (axis_operation_mode == MODE_ORIGIN_NEG);
   assign isInterp = (axis_operation_mode == MODE_INTERP_CONT) || (axis_operation_mode == MODE_INTERP_INCR);
   assign cmdWrite = regWr && (regAddr == OFS_COMMAND);
   // several axes written by one command share this strobe; those with startSelect set start together
   assign startCmd = cmdWrite && startSelect && (regWdata[7:4] == CMD_START_LOW[7:4]) &&
                     (regWdata[7:0] <= CMD_START_ACCEL_DECEL);
   assign stopCmd = cmdWrite && (regWdata[7:0] == CMD_STOP);
   // incremental run ends on the dummy step that completes the whole range
   assign incrDone = (axis_operation_mode == MODE_INTERP_INCR) && pulseTick &&
                     (dummyCount + 1'b1 >= interp_range);
   // interpolation axes also stop on the shared stop line
   assign errHit = errorStop || (isInterp && env[ENV_STP_IN] && sharedStop);

   always_comb begin
      next_state = state;
      doneHit = 1'b0;
      case (state)
         ORIRT_IDLE: begin
            if (startCmd) begin
               next_state = ORIRT_RUN;
            end
         end
         ORIRT_RUN: begin
            if (errHit || stopCmd) begin
               next_state = ORIRT_DONE;
            end else if (isOrigin && orgRise) begin
               if (env[ENV_ZUSE]) begin
                  next_state = ORIRT_ZCOUNT;
               end else begin
                  next_state = ORIRT_DONE;
                  doneHit = 1'b1;
               end
            end else if (incrDone) begin
               next_state = ORIRT_DONE;
            end
         end
         ORIRT_ZCOUNT: begin
            if (errHit || stopCmd) begin
               next_state = ORIRT_DONE;
            end else if (zEdge && zphase_down_counter == 4'h0) begin
               next_state = ORIRT_DONE;
               doneHit = 1'b1;
            end
         end
         ORIRT_DONE: begin
            next_state = ORIRT_IDLE;
         end
         default: begin
            next_state = ORIRT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= ORIRT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign running = (state == ORIRT_RUN) || (state == ORIRT_ZCOUNT);

   // counting is confined to the Z state; outside it the counter reloads the env setting
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         zphase_down_counter <= ENV_RESET[ENV_ZCNT_LO +: 4];
      end else if (state == ORIRT_ZCOUNT && zEdge && zphase_down_counter != 4'h0) begin
         zphase_down_counter <= zphase_down_counter - 4'h1;
      end else if (state != ORIRT_ZCOUNT) begin
         zphase_down_counter <= env[ENV_ZCNT_LO +: 4];
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         zcount_event_flag <= 1'b0;
      end else if (state == ORIRT_ZCOUNT && doneHit && decelerating) begin
         zcount_event_flag <= 1'b1;
      end else if (regWr && regAddr == OFS_EVENT && regWdata[0]) begin
         zcount_event_flag <= 1'b0;
      end
   end

   // deviation clear is a fixed-length pulse
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clrCount <= '0;
      end else if (isOrigin && state == ORIRT_ZCOUNT || isOrigin && state == ORIRT_RUN) begin
         if ((doneHit && env[ENV_CLR_DONE]) ||
             (errHit && env[ENV_CLR_ERR] && !atLowSpeed)) begin
            clrCount <= ($clog2(CLR_PULSE_CYCLES+1))'(CLR_PULSE_CYCLES);
         end
      end else if (clrCount != '0) begin
         clrCount <= clrCount - 1'b1;
      end
   end

   assign deviation_clear_out = (clrCount != '0);

   // counters clear on the origin edge itself, not at the later stop
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         counterOne <= '0;
         counterTwo <= '0;
      end else begin
         if (running && isOrigin && orgRise && env[ENV_C1_ORG] && env[ENV_C1_CLR]) begin
            counterOne <= '0;
         end else if (pulseOut) begin
            counterOne <= direction ? counterOne + 1'b1 : counterOne - 1'b1;
         end
         if (running && isOrigin && orgRise && env[ENV_C2_ORG] && env[ENV_C2_CLR]) begin
            counterTwo <= '0;
         end else if (pulseOut) begin
            counterTwo <= direction ? counterTwo + 1'b1 : counterTwo - 1'b1;
         end
      end
   end

   assign feedAbs = feed_amount[FEED_WIDTH-1] ? (~feed_amount + 1'b1) : feed_amount;
   assign accSum = {1'b0, interpAcc} + {1'b0, feedAbs};

   // dummy axis steps at the largest-feed rate; own axis emits the ratio
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         interpAcc <= '0;
         dummyCount <= '0;
         pulseOut <= 1'b0;
      end else if (!running) begin
         interpAcc <= '0;
         dummyCount <= '0;
         pulseOut <= 1'b0;
      end else if (isInterp && pulseTick) begin
         dummyCount <= dummyCount + 1'b1;
         if (accSum >= {1'b0, interp_range}) begin
            interpAcc <= accSum[FEED_WIDTH-1:0] - interp_range;
            pulseOut <= 1'b1;
         end else begin
            interpAcc <= accSum[FEED_WIDTH-1:0];
            pulseOut <= 1'b0;
         end
      end else begin
         pulseOut <= !isInterp && pulseTick;
      end
   end

   always_comb begin
      if (isInterp) begin
         direction = !feed_amount[FEED_WIDTH-1];
      end else begin
         direction = (axis_operation_mode != MODE_ORIGIN_NEG);
      end
   end

   // open-drain shared lines, driven low while asserting
   assign shared_stop_line_out = 1'b0;
   assign shared_stop_line_oe = isInterp && env[ENV_STP_OUT] && running && errorStop;
   assign shared_slowdown_line_out = 1'b0;
   assign shared_slowdown_line_oe = isInterp && env[ENV_SD_OUT] && running && decelerating;

   // registers; each axis has its own set, so uninvolved axes run alone
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         axis_operation_mode <= MODE_RESET;
         env <= ENV_RESET;
         feed_amount <= '0;
         interp_range <= '0;
      end else if (regWr && !running) begin
         case (regAddr)
            OFS_MODE: axis_operation_mode <= regWdata[7:0];
            OFS_ENV: env <= regWdata[15:0];
            OFS_FEED: feed_amount <= regWdata[FEED_WIDTH-1:0];
            OFS_RANGE: interp_range <= regWdata[FEED_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         case (regAddr)
            OFS_MODE: regRdata <= {24'h00_0000, axis_operation_mode};
            OFS_ENV: regRdata <= {16'h0000, env};
            OFS_FEED: regRdata <= 32'(feed_amount);
            OFS_RANGE: regRdata <= 32'(interp_range);
            OFS_STATUS: regRdata <= {16'h0000, 4'h0, zphase_down_counter, 4'h0,
                                     sharedSlow, deviation_clear_out, direction, running};
            OFS_EVENT: regRdata <= {31'h0000_0000, zcount_event_flag};
            OFS_COUNTER1: regRdata <= 32'(counterOne);
            OFS_COUNTER2: regRdata <= 32'(counterTwo);
            default: regRdata <= 32'h0000_0000;
         endcase
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   AST_ORIGIN_DONE: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == ORIRT_RUN && isOrigin && !env[ENV_ZUSE] && orgRise && !errHit && !stopCmd)
      |=> state == ORIRT_DONE) else $error("origin did not end run");
   AST_CLR_DONE: assert property (@(posedge clk_sys) disable iff (!nrst)
      (doneHit && isOrigin && env[ENV_CLR_DONE]) |=> deviation_clear_out) else $error("no clear on done");
   AST_CLR_ERR: assert property (@(posedge clk_sys) disable iff (!nrst)
      (running && isOrigin && errorStop && env[ENV_CLR_ERR] && !atLowSpeed) |=> deviation_clear_out)
      else $error("no clear on error");
   AST_NO_CLR_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
      (running && isOrigin && errorStop && atLowSpeed && !deviation_clear_out)
      |=> !deviation_clear_out) else $error("clear at low speed");
   AST_CNT1_CLR: assert property (@(posedge clk_sys) disable iff (!nrst)
      (running && isOrigin && orgRise && env[ENV_C1_ORG] && env[ENV_C1_CLR]) |=> counterOne == '0)
      else $error("counter one not cleared");
   AST_Z_DEC: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == ORIRT_ZCOUNT && zEdge && zphase_down_counter != 4'h0)
      |=> zphase_down_counter == $past(zphase_down_counter) - 4'h1) else $error("z not decremented");
   AST_Z_IDLE: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == ORIRT_IDLE) ##1 (state == ORIRT_IDLE) |-> zphase_down_counter == $past(env[ENV_ZCNT_LO +: 4]))
      else $error("idle z value wrong");
   AST_Z_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == ORIRT_ZCOUNT && doneHit && decelerating) |=> zcount_event_flag) else $error("z event lost");
   AST_DIR_INTERP: assert property (@(posedge clk_sys) disable iff (!nrst)
      isInterp |-> direction == !feed_amount[FEED_WIDTH-1]) else $error("interp direction wrong");
   AST_STOP_ALL: assert property (@(posedge clk_sys) disable iff (!nrst)
      (running && isInterp && env[ENV_STP_IN] && sharedStop) |=> !running) else $error("shared stop ignored");

   COV_ORIGIN: cover property (@(posedge clk_sys) disable iff (!nrst) doneHit && !env[ENV_ZUSE]);
   COV_ZDONE: cover property (@(posedge clk_sys) disable iff (!nrst) state == ORIRT_ZCOUNT && doneHit);
   COV_INTERP: cover property (@(posedge clk_sys) disable iff (!nrst) isInterp && pulseOut);
endmodule // orirt_axis

/* shared/orirt_pkg.sv */
package orirt_pkg;
   // operation modes
   localparam logic [7:0] MODE_ORIGIN_POS = 8'h10;
   localparam logic [7:0] MODE_ORIGIN_NEG = 8'h18;
   localparam logic [7:0] MODE_INTERP_CONT = 8'h62;
   localparam logic [7:0] MODE_INTERP_INCR = 8'h63;
   // start and stop commands
   localparam logic [7:0] CMD_START_LOW = 8'h50;
   localparam logic [7:0] CMD_START_HIGH_CONST = 8'h51;
   localparam logic [7:0] CMD_START_HIGH_DECEL = 8'h52;
   localparam logic [7:0] CMD_START_ACCEL_DECEL = 8'h53;
   localparam logic [7:0] CMD_STOP = 8'h49;
   // register offsets
   localparam logic [3:0] OFS_COMMAND = 4'h0;
   localparam logic [3:0] OFS_MODE = 4'h1;
   localparam logic [3:0] OFS_ENV = 4'h2;
   localparam logic [3:0] OFS_FEED = 4'h3;
   localparam logic [3:0] OFS_RANGE = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h5;
   localparam logic [3:0] OFS_EVENT = 4'h6;
   localparam logic [3:0] OFS_COUNTER1 = 4'h7;
   localparam logic [3:0] OFS_COUNTER2 = 4'h8;
   // environment field positions
   localparam int ENV_CLR_DONE = 0;
   localparam int ENV_CLR_ERR = 1;
   localparam int ENV_C1_ORG = 2;
   localparam int ENV_C1_CLR = 3;
   localparam int ENV_C2_ORG = 4;
   localparam int ENV_C2_CLR = 5;
   localparam int ENV_ZUSE = 6;
   localparam int ENV_ZEDGE = 7;
   localparam int ENV_ZCNT_LO = 8;
   localparam int ENV_SD_IN = 12;
   localparam int ENV_SD_OUT = 13;
   localparam int ENV_STP_IN = 14;
   localparam int ENV_STP_OUT = 15;
   // reset values
   localparam logic [15:0] ENV_RESET = 16'h0000;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // deviation clear pulse length
   localparam int CLR_PULSE_NS = 10000;
   localparam int CLK_NS = 8;
   localparam int CLR_PULSE_CYCLES = CLR_PULSE_NS / CLK_NS;
   typedef enum logic [1:0] {
      ORIRT_IDLE = 2'b00,
      ORIRT_RUN = 2'b01,
      ORIRT_ZCOUNT = 2'b11,
      ORIRT_DONE = 2'b10
   } orirt_state_type;
endpackage

/* verification/orirt_field_model.sv */
`timescale 1ns/1ps
module orirt_field_model (
   input wire logic clk_sys,
   input wire logic slowOe,
   input wire logic stopOe,
   input wire logic extStop,
   output logic slowLine,
   output logic stopLine,
   output logic originIn,
   output logic zphaseIn
);
   // wired lines sit on pull-ups: idle high, low while any party pulls
   assign slowLine = !slowOe;
   assign stopLine = !(stopOe || extStop);
   initial begin
      originIn = 1'b0;
      zphaseIn = 1'b0;
   end
   // pins are held long enough to pass the three-stage synchroniser
   task automatic pin(input logic sel, input logic v);
      @(posedge clk_sys);
      if (sel) zphaseIn <= v;
      else originIn <= v;
      repeat (6) @(posedge clk_sys);
      #1;
   endtask
endmodule // orirt_field_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
   import orirt_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic startSelect = 1'b1;
   logic atLowSpeed = 1'b0;
   logic decelerating = 1'b0;
   logic errorStop = 1'b0;
   logic extStop = 1'b0;
   logic pulseTick = 1'b0;
   logic [31:0] regRdata;
   logic originIn, zphaseIn, slowLine, stopLine, slowOe, stopOe;
   logic pulseOut, direction, running, deviation_clear_out;
   int n_fail = 0;
   int checks = 0;
   int cnt;
   int nPulse = 0;
   int clrLen = 0;
   always #4 clk_sys = ~clk_sys;
   // outputs are counted mid-cycle, away from the edge that launches them
   always @(negedge clk_sys) begin
      if (pulseOut === 1'b1) nPulse++;
      if (deviation_clear_out === 1'b1) clrLen++;
   end
   orirt_axis orirt_axis_i (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .startSelect(startSelect), .originIn(originIn),
      .zphaseIn(zphaseIn), .atLowSpeed(atLowSpeed), .decelerating(decelerating), .errorStop(errorStop),
      .shared_slowdown_line_in(slowLine), .shared_slowdown_line_out(), .shared_slowdown_line_oe(slowOe),
      .shared_stop_line_in(stopLine), .shared_stop_line_out(), .shared_stop_line_oe(stopOe),
      .pulseTick(pulseTick), .pulseOut(pulseOut), .direction(direction), .running(running),
      .deviation_clear_out(deviation_clear_out));
   orirt_field_model orirt_field_model_i (.clk_sys(clk_sys), .slowOe(slowOe), .stopOe(stopOe),
      .extStop(extStop), .slowLine(slowLine), .stopLine(stopLine), .originIn(originIn), .zphaseIn(zphaseIn));
   task automatic results();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] exp);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      chk(regRdata & msk, exp, "read");
   endtask
   task automatic go(input logic [7:0] cmd);
      wr(OFS_COMMAND, {24'h00_0000, cmd});
      tick(2);
      chk(running, 1'b1, "started");
   endtask
   task automatic waitStop();
      cnt = 0;
      while (running === 1'b1 && cnt < 50) begin
         tick(1);
         cnt++;
      end
      chk(running, 1'b0, "stopped");
   endtask
   // clrLen is zeroed before the event, so the whole pulse is counted
   task automatic devClr(input logic exp);
      cnt = 0;
      while (deviation_clear_out === 1'b1 && cnt < 2000) begin
         tick(1);
         cnt++;
      end
      chk(clrLen != 0, exp, "deviation clear");
      if (exp) chk(clrLen, CLR_PULSE_CYCLES, "deviation clear length");
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         pulseTick <= 1'b1;
         @(posedge clk_sys);
         pulseTick <= 1'b0;
         tick(2);
      end
   endtask
   initial begin
      #400000;
      n_fail++;
      $display("FAIL %0t run did not finish", $time);
      results();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(OFS_MODE, ALL, {24'h00_0000, MODE_RESET});
      rd(OFS_ENV, ALL, {16'h0000, ENV_RESET});
      rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
      rd(4'hF, ALL, 32'h0000_0000);
      wr(OFS_ENV, 32'h0000_0F00);
      rd(OFS_STATUS, 32'h0000_0F00, 32'h0000_0F00);
      // origin return on the switch alone, counter one cleared at the origin
      wr(OFS_MODE, {24'h00_0000, MODE_ORIGIN_POS});
      wr(OFS_ENV, 32'h0000_030D);
      go(CMD_START_HIGH_CONST);
      chk(direction, 1'b1, "direction");
      ticks(4);
      clrLen = 0;
      orirt_field_model_i.pin(1'b0, 1'b1);
      waitStop();
      devClr(1'b1);
      rd(OFS_COUNTER1, ALL, 32'h0000_0000);
      orirt_field_model_i.pin(1'b0, 1'b0);
      // two rising Z edges needed, count ends while decelerating; pulses after the origin still count
      wr(OFS_ENV, 32'h0000_01CC);
      go(CMD_START_ACCEL_DECEL);
      ticks(2);
      @(posedge clk_sys);
      decelerating <= 1'b1;
      orirt_field_model_i.pin(1'b0, 1'b1);
      rd(OFS_STATUS, 32'h0000_0F01, 32'h0000_0101);
      ticks(3);
      orirt_field_model_i.pin(1'b1, 1'b1);
      orirt_field_model_i.pin(1'b1, 1'b0);
      rd(OFS_STATUS, 32'h0000_0F01, 32'h0000_0001);
      orirt_field_model_i.pin(1'b1, 1'b1);
      waitStop();
      rd(OFS_COUNTER1, ALL, 32'h0000_0003);
      orirt_field_model_i.pin(1'b1, 1'b0);
      orirt_field_model_i.pin(1'b1, 1'b1);
      rd(OFS_STATUS, 32'h0000_0F01, 32'h0000_0100);
      orirt_field_model_i.pin(1'b1, 1'b0);
      rd(OFS_EVENT, 32'h0000_0001, 32'h0000_0001);
      wr(OFS_EVENT, 32'h0000_0001);
      rd(OFS_EVENT, 32'h0000_0001, 32'h0000_0000);
      @(posedge clk_sys);
      decelerating <= 1'b0;
      orirt_field_model_i.pin(1'b0, 1'b0);
      // count setting zero on falling edges: a rising edge must not end it
      wr(OFS_ENV, 32'h0000_0040);
      go(CMD_START_HIGH_CONST);
      orirt_field_model_i.pin(1'b0, 1'b1);
      orirt_field_model_i.pin(1'b1, 1'b1);
      chk(running, 1'b1, "rising edge ignored");
      orirt_field_model_i.pin(1'b1, 1'b0);
      waitStop();
      orirt_field_model_i.pin(1'b0, 1'b0);
      // error stops: no deviation clear at low start speed, one above it; then an unselected axis stays idle
      wr(OFS_ENV, 32'h0000_0002);
      clrLen = 0;
      go(CMD_START_ACCEL_DECEL);
      @(posedge clk_sys);
      atLowSpeed <= 1'b1;
      errorStop <= 1'b1;
      waitStop();
      devClr(1'b0);
      @(posedge clk_sys);
      errorStop <= 1'b0;
      atLowSpeed <= 1'b0;
      clrLen = 0;
      go(CMD_START_ACCEL_DECEL);
      @(posedge clk_sys);
      errorStop <= 1'b1;
      waitStop();
      devClr(1'b1);
      @(posedge clk_sys);
      errorStop <= 1'b0;
      startSelect <= 1'b0;
      wr(OFS_COMMAND, {24'h00_0000, CMD_START_HIGH_CONST});
      tick(3);
      chk(running, 1'b0, "unselected axis idle");
      @(posedge clk_sys);
      startSelect <= 1'b1;
      // continuous interpolation, negative feed half the range
      wr(OFS_MODE, {24'h00_0000, MODE_INTERP_CONT});
      wr(OFS_ENV, 32'h0000_F000);
      wr(OFS_FEED, 32'hFFFF_FFFB);
      wr(OFS_RANGE, 32'h0000_000A);
      go(CMD_START_ACCEL_DECEL);
      chk(direction, 1'b0, "direction");
      nPulse = 0;
      ticks(10);
      tick(4);
      chk(nPulse, 32'h0000_0005, "pulses");
      chk(running, 1'b1, "still running");
      @(posedge clk_sys);
      decelerating <= 1'b1;
      #1;
      chk(slowOe, 1'b1, "shared slowdown pulled");
      tick(4);
      rd(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
      @(posedge clk_sys);
      decelerating <= 1'b0;
      wr(OFS_COMMAND, {24'h00_0000, CMD_STOP});
      waitStop();
      wr(OFS_MODE, {24'h00_0000, MODE_INTERP_INCR});
      wr(OFS_FEED, 32'h0000_0003);
      go(CMD_START_HIGH_CONST);
      chk(direction, 1'b1, "direction");
      // the own pull lasts only until the stop, so look right after raising the error
      @(posedge clk_sys);
      errorStop <= 1'b1;
      #1;
      chk(stopOe, 1'b1, "shared stop pulled");
      waitStop();
      @(posedge clk_sys);
      errorStop <= 1'b0;
      go(CMD_START_HIGH_CONST);
      @(posedge clk_sys);
      extStop <= 1'b1;
      waitStop();
      @(posedge clk_sys);
      extStop <= 1'b0;
      // let the released stop line pass the synchroniser before the next start
      tick(4);
      // incremental run ends by itself once the dummy axis covers the range
      nPulse = 0;
      go(CMD_START_HIGH_CONST);
      ticks(10);
      tick(2);
      chk(nPulse, 32'h0000_0003, "incremental pulses");
      waitStop();
      results();
   end
endmodule // tb
